// ==== rtl/abs_pos_out.sv ====
/*
 * Absolute position output of a servo drive: turn count frame on phase A,
 * in-revolution quadrature train on A/B, then incremental pass-through,
 * and periodic serial frames of the full position on the serial line.
 * Assumes encoder data and incremental pulses come from logic on SYS_CLK;
 * the request line comes from a pin and is synchronised here.
 */
`timescale 1ns/1ps
module abs_pos_out
   import abs_pos_pkg::*;
#(
   parameter int unsigned PPR_W      = 22,
   parameter int unsigned TURNS_W    = 16,
   parameter int unsigned BIT_CYC    = DEF_BIT_CYC,
   parameter int unsigned AUTO_CYC   = DEF_AUTO_CYC,
   parameter int unsigned PERIOD_CYC = DEF_PERIOD_CYC
)(
   input  wire logic               SYS_CLK,
   input  wire logic               RST_N,
   input  wire logic [3:0]         FUNCTION_SELECT_PARAM,
   input  wire logic [1:0]         NATIVE_ENC_TYPE,
   input  wire logic               REQUEST_USED,
   input  wire logic [PPR_W-1:0]   OUTPUT_PULSES_PER_REV,
   input  wire logic               ENC_VALID,
   input  wire logic [TURNS_W-1:0] ENC_TURNS,
   input  wire logic [PPR_W-1:0]   ENC_POS_IN_REV,
   input  wire logic               POSITION_REQUEST_IN,
   input  wire logic               INC_A,
   input  wire logic               INC_B,
   input  wire logic               INC_ORIGIN,
   output logic                    PHASE_A_DIVIDED_OUT,
   output logic                    PHASE_B_DIVIDED_OUT,
   output logic                    ORIGIN_DIVIDED_OUT,
   output logic                    SERIAL_POSITION_OUT,
   output logic                    REPORT_DONE
);
   typedef struct packed {
      seq_e               st;
      logic [1:0]         enc;
      logic               use_req;
      logic               req_s1;
      logic               req_s2;
      logic [31:0]        dly;
      logic [PPR_W-1:0]   qcnt;
      logic [1:0]         quad;
      logic [31:0]        div;
      logic [MSG_W-1:0]   msg;
      logic [2:0]         nbytes;
      logic [9:0]         tx_sh;
      logic [3:0]         tx_bits;
      logic [31:0]        tx_cnt;
      logic [31:0]        per;
      logic               a;
      logic               b;
      logic               org;
      logic               serial_position_out;
      logic               done;
   } state_s;

   state_s s_q;
   state_s s_d;

   logic             wr_valid;
   logic             wr_ready;
   logic             rd_valid;
   logic             rd_ready;
   logic [7:0]       rd_data;
   logic             fifo_empty;
   logic             line;
   logic             tx_idle;
   logic             start;
   logic [MSG_W-1:0] abs_pos;

   byte_fifo #(
      .WIDTH (BYTE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .SYS_CLK  (SYS_CLK),
      .RST_N    (RST_N),
      .WR_VALID (wr_valid),
      .WR_READY (wr_ready),
      .WR_DATA  (s_q.msg[7:0]),
      .RD_VALID (rd_valid),
      .RD_READY (rd_ready),
      .RD_DATA  (rd_data),
      .EMPTY    (fifo_empty),
      .FULL     ()
   );

   always_comb
   begin
      s_d      = s_q;
      tx_idle  = (s_q.tx_bits == 4'h0);
      line     = tx_idle ? 1'b1 : s_q.tx_sh[0];
      wr_valid = (s_q.nbytes != 3'h0);
      rd_ready = tx_idle;
      start    = s_q.use_req ? s_q.req_s2 : (s_q.dly >= AUTO_CYC - 1);
      abs_pos  = MSG_W'(ENC_TURNS * OUTPUT_PULSES_PER_REV) + MSG_W'(ENC_POS_IN_REV);
      if (s_q.enc == ENC_SINGLE)
      begin
         abs_pos = MSG_W'(ENC_POS_IN_REV);
      end

      s_d.req_s1 = POSITION_REQUEST_IN;
      s_d.req_s2 = s_q.req_s1;

      // Frame loader: stalls while the FIFO is full
      if (wr_valid && wr_ready)
      begin
         s_d.msg    = s_q.msg >> BYTE_W;
         s_d.nbytes = s_q.nbytes - 3'h1;
      end

      // Serial transmitter fed from the FIFO
      if (tx_idle)
      begin
         if (rd_valid)
         begin
            s_d.tx_sh   = {1'b1, rd_data, 1'b0};
            s_d.tx_bits = FRAME_BITS;
            s_d.tx_cnt  = BIT_CYC - 1;
         end
      end
      else if (s_q.tx_cnt == 32'h0)
      begin
         s_d.tx_sh   = {1'b1, s_q.tx_sh[9:1]};
         s_d.tx_bits = s_q.tx_bits - 4'h1;
         s_d.tx_cnt  = BIT_CYC - 1;
      end
      else
      begin
         s_d.tx_cnt = s_q.tx_cnt - 32'h1;
      end

      case (s_q.st)
         ST_CAPTURE:
         begin
            // Usage digit is caught once after reset, so later changes need a restart
            case (FUNCTION_SELECT_PARAM)
               USE_INC:    s_d.enc = ENC_INC;
               USE_SINGLE: s_d.enc = ENC_SINGLE;
               default:    s_d.enc = NATIVE_ENC_TYPE;
            endcase
            s_d.use_req = REQUEST_USED;
            s_d.st      = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (!start)
            begin
               s_d.dly = s_q.dly + 32'h1;
            end
            else if (ENC_VALID)
            begin
               if (s_q.enc == ENC_INC)
               begin
                  s_d.st   = ST_RUN;
                  s_d.done = 1'b1;
               end
               else
               begin
                  s_d.msg    = '0;
                  s_d.msg[TURNS_W-1:0] = (s_q.enc == ENC_SINGLE) ? '0 : ENC_TURNS;
                  s_d.nbytes = TURNS_BYTES;
                  s_d.qcnt   = ENC_POS_IN_REV;
                  s_d.st     = ST_TURNS;
               end
            end
         end
         ST_TURNS:
         begin
            if (s_q.nbytes == 3'h0 && fifo_empty && tx_idle)
            begin
               s_d.div = '0;
               s_d.st  = ST_PULSE;
            end
         end
         ST_PULSE:
         begin
            if (s_q.qcnt == '0)
            begin
               s_d.st   = ST_RUN;
               s_d.done = 1'b1;
               s_d.per  = '0;
            end
            else if (s_q.div >= QUAD_STEP_CYC - 1)
            begin
               s_d.div  = '0;
               s_d.quad = s_q.quad + 2'h1;
               s_d.qcnt = s_q.qcnt - 1'b1;
            end
            else
            begin
               s_d.div = s_q.div + 32'h1;
            end
         end
         ST_RUN:
         begin
            if (s_q.enc != ENC_INC)
            begin
               if (s_q.per >= PERIOD_CYC - 1)
               begin
                  s_d.per = '0;
                  if (s_q.nbytes == 3'h0)
                  begin
                     s_d.msg    = abs_pos;
                     s_d.nbytes = ABS_BYTES;
                  end
               end
               else
               begin
                  s_d.per = s_q.per + 32'h1;
               end
            end
         end
         default:
         begin
            s_d.st = ST_CAPTURE;
         end
      endcase

      // Pin drive, registered
      s_d.org = INC_ORIGIN;
      s_d.serial_position_out = (s_q.st == ST_RUN) ? line : 1'b1;
      case (s_q.st)
         ST_TURNS:
         begin
            s_d.a = line;
            s_d.b = 1'b0;
         end
         ST_PULSE:
         begin
            s_d.a = s_q.quad[1];
            s_d.b = s_q.quad[1] ^ s_q.quad[0];
         end
         ST_RUN:
         begin
            s_d.a = INC_A;
            s_d.b = INC_B;
         end
         default:
         begin
            s_d.a = 1'b1;
            s_d.b = 1'b0;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         s_q     <= '0;
         s_q.st  <= ST_CAPTURE;
         s_q.a   <= 1'b1;
         s_q.serial_position_out <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign PHASE_A_DIVIDED_OUT = s_q.a;
   assign PHASE_B_DIVIDED_OUT = s_q.b;
   assign ORIGIN_DIVIDED_OUT  = s_q.org;
   assign SERIAL_POSITION_OUT = s_q.serial_position_out;
   assign REPORT_DONE         = s_q.done;
endmodule

// ==== rtl/abs_pos_pkg.sv ====
/*
 * Shared constants for the absolute position report logic: encoder usage
 * codes, sequence states, frame layout and timing figures.
 * Assumes a single 125 MHz system clock.
 */
package abs_pos_pkg;
   localparam int unsigned CLK_HZ           = 125_000_000;
   localparam int unsigned CLK_PERIOD_NS    = 8;
   // Usage digit of the function select parameter
   localparam logic [3:0]  USE_NATIVE       = 4'h0;
   localparam logic [3:0]  USE_INC          = 4'h1;
   localparam logic [3:0]  USE_SINGLE       = 4'h2;
   // Effective encoder type
   localparam logic [1:0]  ENC_INC          = 2'h0;
   localparam logic [1:0]  ENC_SINGLE       = 2'h1;
   localparam logic [1:0]  ENC_MULTI        = 2'h2;
   // Message layout
   localparam int unsigned BYTE_W           = 8;
   localparam int unsigned MSG_W            = 40;
   localparam logic [2:0]  TURNS_BYTES      = 3'h2;
   localparam logic [2:0]  ABS_BYTES        = 3'h5;
   localparam logic [3:0]  FRAME_BITS       = 4'ha;
   localparam int unsigned FIFO_DEPTH       = 32;
   // Quadrature step: least time per edge, rounded up to cycles
   localparam int unsigned QUAD_STEP_NS     = 368;
   localparam int unsigned QUAD_STEP_CYC    = (QUAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Serial bit time
   localparam int unsigned BAUD             = 9600;
   localparam int unsigned DEF_BIT_CYC      = CLK_HZ / BAUD;
   // Delay before a report without request
   localparam int unsigned AUTO_DELAY_MS    = 100;
   localparam int unsigned DEF_AUTO_CYC     = AUTO_DELAY_MS * (CLK_HZ / 1000);
   // Period of the serial position messages
   localparam int unsigned REPORT_PERIOD_MS = 10;
   localparam int unsigned DEF_PERIOD_CYC   = REPORT_PERIOD_MS * (CLK_HZ / 1000);

   typedef enum logic [4:0] {
      ST_CAPTURE = 5'b00001,
      ST_WAIT    = 5'b00010,
      ST_TURNS   = 5'b00100,
      ST_PULSE   = 5'b01000,
      ST_RUN     = 5'b10000
   } seq_e;
endpackage

// ==== rtl/byte_fifo.sv ====
/*
 * Synchronous FIFO with valid/ready on both sides, width and depth as
 * parameters. Depth must be a power of two.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module byte_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
)(
   input  wire logic             SYS_CLK,
   input  wire logic             RST_N,
   input  wire logic             WR_VALID,
   output logic                  WR_READY,
   input  wire logic [WIDTH-1:0] WR_DATA,
   output logic                  RD_VALID,
   input  wire logic             RD_READY,
   output logic [WIDTH-1:0]      RD_DATA,
   output logic                  EMPTY,
   output logic                  FULL
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_q;
   logic [AW:0]      rp_q;

   assign EMPTY    = (wp_q == rp_q);
   assign FULL     = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   assign WR_READY = !FULL;
   assign RD_VALID = !EMPTY;
   assign RD_DATA  = mem[rp_q[AW-1:0]];

   always_ff @(posedge SYS_CLK)
   begin
      if (WR_VALID && !FULL)
      begin
         mem[wp_q[AW-1:0]] <= WR_DATA;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         wp_q <= '0;
         rp_q <= '0;
      end
      else
      begin
         if (WR_VALID && !FULL)
         begin
            wp_q <= wp_q + 1'b1;
         end
         if (RD_READY && !EMPTY)
         begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule

// ==== sim/abs_pos_out_chk.sv ====
/* Port checker for abs_pos_out, bound to every instance.
   Assumes one clock domain and the design's reset. */
`timescale 1ns/1ps
module abs_pos_out_chk #(
   parameter int unsigned BIT_CYC  = 4,
   parameter int unsigned AUTO_CYC = 20
)(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic REQUEST_USED,
   input wire logic POSITION_REQUEST_IN,
   input wire logic INC_A,
   input wire logic INC_B,
   input wire logic PHASE_A_DIVIDED_OUT,
   input wire logic PHASE_B_DIVIDED_OUT,
   input wire logic SERIAL_POSITION_OUT,
   input wire logic REPORT_DONE
);
   logic [15:0] since_q, alo_q, slo_q;
   logic        seen_q;
   always_ff @(posedge SYS_CLK or negedge RST_N)
      if (!RST_N)
      begin
         since_q <= '0;
         alo_q   <= '0;
         slo_q   <= '0;
         seen_q  <= 1'b0;
      end
      else
      begin
         since_q <= (since_q < 16'(AUTO_CYC)) ? since_q + 16'h1 : since_q;
         alo_q   <= PHASE_A_DIVIDED_OUT ? '0 : alo_q + 16'h1;
         slo_q   <= SERIAL_POSITION_OUT ? '0 : slo_q + 16'h1;
         seen_q  <= seen_q | POSITION_REQUEST_IN;
      end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   sequence s_quiet;
      PHASE_A_DIVIDED_OUT && !PHASE_B_DIVIDED_OUT && !REPORT_DONE;
   endsequence
   sequence s_line_idle;
      SERIAL_POSITION_OUT[*8];
   endsequence
   property p_pso_idle;
      !REPORT_DONE |-> SERIAL_POSITION_OUT;
   endproperty
   a_pso_idle: assert property (p_pso_idle) else $error("serial active early");
   property p_first_gap;
      $rose(REPORT_DONE) |-> s_line_idle;
   endproperty
   a_first_gap: assert property (p_first_gap) else $error("serial right after done");
   property p_follow;
      REPORT_DONE && $past(REPORT_DONE) |-> {PHASE_A_DIVIDED_OUT, PHASE_B_DIVIDED_OUT} == $past({INC_A, INC_B});
   endproperty
   a_follow: assert property (p_follow) else $error("A/B not tracking");
   property p_sticky;
      REPORT_DONE |=> REPORT_DONE;
   endproperty
   a_sticky: assert property (p_sticky) else $error("done dropped");
   property p_gray;
      !REPORT_DONE |-> !($changed(PHASE_A_DIVIDED_OUT) && $changed(PHASE_B_DIVIDED_OUT));
   endproperty
   a_gray: assert property (p_gray) else $error("A and B moved together");
   property p_a_bits;
      $rose(PHASE_A_DIVIDED_OUT) && !PHASE_B_DIVIDED_OUT && !REPORT_DONE |-> (alo_q % 16'(BIT_CYC)) == 16'h0;
   endproperty
   a_a_bits: assert property (p_a_bits) else $error("turn frame bit length");
   property p_s_bits;
      $rose(SERIAL_POSITION_OUT) |-> (slo_q % 16'(BIT_CYC)) == 16'h0;
   endproperty
   a_s_bits: assert property (p_s_bits) else $error("serial bit length");
   property p_auto_hold;
      !REQUEST_USED && since_q < 16'(AUTO_CYC) |-> s_quiet;
   endproperty
   a_auto_hold: assert property (p_auto_hold) else $error("report before delay");
   property p_req_hold;
      REQUEST_USED && !seen_q |-> s_quiet;
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("report without request");
endmodule

bind abs_pos_out abs_pos_out_chk #(.BIT_CYC(BIT_CYC), .AUTO_CYC(AUTO_CYC)) u_chk (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .REQUEST_USED(REQUEST_USED), .POSITION_REQUEST_IN(POSITION_REQUEST_IN),
   .INC_A(INC_A), .INC_B(INC_B), .PHASE_A_DIVIDED_OUT(PHASE_A_DIVIDED_OUT),
   .PHASE_B_DIVIDED_OUT(PHASE_B_DIVIDED_OUT), .SERIAL_POSITION_OUT(SERIAL_POSITION_OUT), .REPORT_DONE(REPORT_DONE));

// ==== sim/host_model.sv ====
/* Host side model: 8N1 receivers on phase A and on the serial line, a quadrature
   edge counter and the request line. Assumes a bit time of 4 clocks. */
`timescale 1ns/1ps
module uart_rx #(
   parameter int BIT_CYC = 4,
   parameter int MAXB    = 5
)(
   input  wire logic   clk,
   input  wire logic   rst_n,
   input  wire logic   en,
   input  wire logic   line,
   output logic [39:0] sr,
   output int          nb,
   output int          fe
);
   always @(posedge clk)
      if (!rst_n)
      begin
         nb = 0;
         fe = 0;
      end
   // Bits sampled mid-cell, LSB first, bytes shifted in from the top
   always @(negedge line)
      if (rst_n && en && nb < MAXB)
      begin
         repeat (BIT_CYC / 2) @(negedge clk);
         for (int i = 0; i < 9; i++)
         begin
            repeat (BIT_CYC) @(negedge clk);
            if (i < 8)
               sr = {line, sr[39:1]};
            else if (!line)
               fe++;
         end
         nb++;
      end
endmodule

module host_model (
   input  wire logic   clk,
   input  wire logic   rst_n,
   input  wire logic   want,
   input  wire logic   pha,
   input  wire logic   phb,
   input  wire logic   serial_position_out,
   input  wire logic   done,
   output logic        req,
   output logic [39:0] a_sr,
   output logic [39:0] s_sr,
   output int          a_nb,
   output int          s_nb,
   output int          qcnt,
   output int          ferr
);
   logic pa_q, pb_q, go_q, done_q;
   int   fa, fs;
   assign req  = want;
   assign ferr = fa + fs;
   uart_rx #(.MAXB(2)) u_a (.clk(clk), .rst_n(rst_n), .en(!phb && !done), .line(pha), .sr(a_sr),
      .nb(a_nb), .fe(fa));
   uart_rx #(.MAXB(5)) u_s (.clk(clk), .rst_n(rst_n), .en(done), .line(serial_position_out), .sr(s_sr), .nb(s_nb), .fe(fs));
   // The first edge after the turn frame only enters state 00; the last step
   // shows together with the rise of done, so done is taken one edge late
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         qcnt = 0;
         go_q = 1'b0;
      end
      else if (a_nb == 2 && !done_q && {pha, phb} != {pa_q, pb_q})
      begin
         qcnt = qcnt + int'(go_q);
         go_q = 1'b1;
      end
      pa_q = pha;
      pb_q = phb;
      done_q = done;
   end
endmodule

// ==== sim/tb_top.sv ====
/* Bench for abs_pos_out: power-up cases over usage, encoder type and request mode.
   Assumes host_model and the bound checker. */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin failures++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, s); end end
module tb_top;
   import abs_pos_pkg::*;
   logic        SYS_CLK, RST_N, REQUEST_USED, ENC_VALID, INC_A, INC_B, INC_ORIGIN, want;
   logic [3:0]  FUNCTION_SELECT_PARAM;
   logic [1:0]  NATIVE_ENC_TYPE;
   logic [21:0] OUTPUT_PULSES_PER_REV, ENC_POS_IN_REV;
   logic [15:0] ENC_TURNS;
   logic [31:0] rnd;
   logic [39:0] a_sr, s_sr;
   wire  logic  req, pha, phb, serial_position_out, done, org;
   int          failures, n_checks, a_nb, s_nb, qcnt, ferr;
   abs_pos_out #(.BIT_CYC(4), .AUTO_CYC(20), .PERIOD_CYC(200)) DUT (
      .SYS_CLK(SYS_CLK), .RST_N(RST_N), .FUNCTION_SELECT_PARAM(FUNCTION_SELECT_PARAM),
      .NATIVE_ENC_TYPE(NATIVE_ENC_TYPE), .REQUEST_USED(REQUEST_USED), .OUTPUT_PULSES_PER_REV(OUTPUT_PULSES_PER_REV),
      .ENC_VALID(ENC_VALID), .ENC_TURNS(ENC_TURNS), .ENC_POS_IN_REV(ENC_POS_IN_REV), .POSITION_REQUEST_IN(req),
      .INC_A(INC_A), .INC_B(INC_B), .INC_ORIGIN(INC_ORIGIN), .PHASE_A_DIVIDED_OUT(pha), .PHASE_B_DIVIDED_OUT(phb),
      .ORIGIN_DIVIDED_OUT(org), .SERIAL_POSITION_OUT(serial_position_out), .REPORT_DONE(done));
   host_model u_host (.clk(SYS_CLK), .rst_n(RST_N), .want(want), .pha(pha), .phb(phb), .serial_position_out(serial_position_out), .done(done),
      .req(req), .a_sr(a_sr), .s_sr(s_sr), .a_nb(a_nb), .s_nb(s_nb), .qcnt(qcnt), .ferr(ferr));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] exp_turns(input logic [3:0] u, input logic [1:0] n, input logic [15:0] t);
      return (u == USE_SINGLE || (u == USE_NATIVE && n == ENC_SINGLE)) ? 16'h0 : t;
   endfunction
   task automatic print_verdict;
      if (failures == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic run(input logic [3:0] u, input logic [1:0] n, input logic rq);
      int k;
      @(negedge SYS_CLK);
      rnd = lfsr(rnd);
      RST_N = 1'b0;
      want = 1'b0;
      FUNCTION_SELECT_PARAM = u;
      NATIVE_ENC_TYPE = n;
      REQUEST_USED = rq;
      ENC_TURNS = rnd[15:0];
      OUTPUT_PULSES_PER_REV = 22'(rnd[31:18]) + 22'h4;
      ENC_POS_IN_REV = 22'(rnd[17:16]);
      INC_A = 1'b1;
      INC_B = 1'b0;
      INC_ORIGIN = 1'b0;
      ENC_VALID = 1'b0;
      repeat (3) @(negedge SYS_CLK);
      RST_N = 1'b1;
      repeat (3) @(negedge SYS_CLK);
      FUNCTION_SELECT_PARAM = (u == USE_INC) ? USE_NATIVE : USE_INC;
      // No report while the encoder data is not yet valid
      repeat (30) @(negedge SYS_CLK);
      `CHK("held_idle", 3'b100, {pha, phb, done})
      ENC_VALID = 1'b1;
      if (rq)
      begin
         repeat (60) @(negedge SYS_CLK);
         `CHK("early_frame", 0, a_nb)
         want = 1'b1;
      end
      k = 0;
      while (s_nb < 5 && k < 3000)
      begin
         @(negedge SYS_CLK);
         k++;
      end
      if (u == USE_INC || (u == USE_NATIVE && n == ENC_INC))
         `CHK("inc_serial", 0, s_nb)
      else
      begin
         if (k == 3000)
         begin
            failures++;
            print_verdict;
         end
         `CHK("turns", exp_turns(u, n, ENC_TURNS), a_sr[39:24])
         `CHK("quad_steps", 32'(ENC_POS_IN_REV), qcnt)
         `CHK("abs_pos", 40'(exp_turns(u, n, ENC_TURNS)) * 40'(OUTPUT_PULSES_PER_REV) + 40'(ENC_POS_IN_REV), s_sr)
         `CHK("frame_err", 0, ferr)
         `CHK("done", 1'b1, done)
         repeat (12)
         begin
            rnd = lfsr(rnd);
            INC_A = rnd[0];
            INC_B = rnd[1];
            INC_ORIGIN = rnd[2];
            @(negedge SYS_CLK);
            `CHK("inc_pass", {INC_A, INC_B}, {pha, phb})
            `CHK("origin", INC_ORIGIN, org)
         end
      end
   endtask
   initial
   begin
      SYS_CLK = 1'b0;
      forever #4 SYS_CLK = ~SYS_CLK;
   end
   initial
   begin
      RST_N = 1'b0;
      want = 1'b0;
      REQUEST_USED = 1'b0;
      ENC_VALID = 1'b1;
      INC_A = 1'b1;
      INC_B = 1'b0;
      INC_ORIGIN = 1'b0;
      FUNCTION_SELECT_PARAM = USE_NATIVE;
      NATIVE_ENC_TYPE = ENC_MULTI;
      OUTPUT_PULSES_PER_REV = 22'h10;
      ENC_TURNS = 16'h0;
      ENC_POS_IN_REV = 22'h1;
      rnd = 32'h2bcc;
      failures = 0;
      n_checks = 0;
      run(USE_NATIVE, ENC_MULTI, 1'b0);
      run(USE_NATIVE, ENC_MULTI, 1'b1);
      run(USE_SINGLE, ENC_MULTI, 1'b0);
      run(USE_NATIVE, ENC_SINGLE, 1'b1);
      run(USE_INC, ENC_MULTI, 1'b0);
      run(USE_NATIVE, ENC_INC, 1'b0);
      print_verdict;
   end
endmodule
